// [lcf_regs.sv]
// channel enable registers and sticky open and short fault flags
//
// Function
// [R1] Channels 1 to 8 are enabled by an eight-bit register at 0x05, bit 7 for channel 8.
// [R2] A channel whose enable bit is 0 has its current source held off, 1 lets it run.
// [R3] Enable bits are host read-write and reset to 1 so all channels start enabled.
// [R4] Open-load flags of channels 9 to 16 read at 0x06, bit 7 for channel 16.
// [R5] Open-load flags of channels 1 to 8 read at 0x07, bit 7 for channel 8.
// [R6] A detected open-load fault sets that channel's open flag to 1.
// [R7] Open flags read 0 until a fault is seen and reset to 0.
// [R8] Short flags of channels 9 to 16 read at 0x08, bit 7 for channel 16.
// [R9] A detected short fault sets that channel's short flag to 1.
// [R10] Short flags read 0 until a fault is seen and reset to 0.
// [R11] Channels 9 to 16 are enabled by a register at 0x04, bit 7 for channel 16.
// [R12] Short flags of channels 1 to 8 read at 0x09, bit 7 for channel 8.
// [R13] Writes to the fault registers are ignored and leave the flags as they are.
// [R14] The host reads the fault registers after a fault indication to find the channels.
`timescale 1ns/1ns
`default_nettype none

module lcf_regs (
    input  wire logic            CLK,
    input  wire logic            RST,
    input  wire lcf_pkg::lcf_req_t REG_REQ,
    output logic [7:0]           REG_RDATA,
    input  wire logic [15:0]     OPEN_DET,
    input  wire logic [15:0]     SHORT_DET,
    output logic [15:0]          CHAN_ON
);

    // ========================================================================
    // state
    lcf_pkg::lcf_en_low_t en_low_reg,  en_low_next;
    logic [7:0]           en_high_reg, en_high_next;
    logic [15:0]          open_s1_reg, open_s1_next;
    logic [15:0]          open_s2_reg, open_s2_next;
    logic [15:0]          short_s1_reg, short_s1_next;
    logic [15:0]          short_s2_reg, short_s2_next;
    logic [15:0]          open_flag_reg, open_flag_next;
    logic [15:0]          short_flag_reg, short_flag_next;
    logic [7:0]           rdata_reg,  rdata_next;

    // ========================================================================
    // enable registers
    always_comb begin
        en_low_next  = en_low_reg;
        en_high_next = en_high_reg;
        if (REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW) begin
            en_low_next = lcf_pkg::lcf_en_low_t'(REG_REQ.wdata); // see [R1] see [R3]
        end
        if (REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_HIGH) begin
            en_high_next = REG_REQ.wdata; // see [R11]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_low_reg  <= lcf_pkg::lcf_en_low_t'(lcf_pkg::EN_RST); // see [R3]
            en_high_reg <= lcf_pkg::EN_RST;
        end else begin
            en_low_reg  <= en_low_next;
            en_high_reg <= en_high_next;
        end
    end

    // the enable flops drive the current-source gates directly
    assign CHAN_ON = {en_high_reg, en_low_reg}; // see [R2]

    // ========================================================================
    // detector synchronisers and sticky flags
    // detectors are analogue and unclocked, so two flops before any logic
    always_comb begin
        open_s1_next    = OPEN_DET;
        open_s2_next    = open_s1_reg;
        short_s1_next   = SHORT_DET;
        short_s2_next   = short_s1_reg;
        // sticky: no write path at all, so host writes cannot disturb them
        open_flag_next  = open_flag_reg | open_s2_reg;   // see [R6] see [R13]
        short_flag_next = short_flag_reg | short_s2_reg; // see [R9] see [R13]
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            open_s1_reg    <= lcf_pkg::FLAG_RST;
            open_s2_reg    <= lcf_pkg::FLAG_RST;
            short_s1_reg   <= lcf_pkg::FLAG_RST;
            short_s2_reg   <= lcf_pkg::FLAG_RST;
            open_flag_reg  <= lcf_pkg::FLAG_RST;  // see [R7]
            short_flag_reg <= lcf_pkg::FLAG_RST;  // see [R10]
        end else begin
            open_s1_reg    <= open_s1_next;
            open_s2_reg    <= open_s2_next;
            short_s1_reg   <= short_s1_next;
            short_s2_reg   <= short_s2_next;
            open_flag_reg  <= open_flag_next;
            short_flag_reg <= short_flag_next;
        end
    end

    // ========================================================================
    // read path
    // read data is registered and held until the next read
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_REQ.rd) begin
            unique case (REG_REQ.addr)
                lcf_pkg::ADDR_EN_HIGH:    rdata_next = en_high_reg;
                lcf_pkg::ADDR_EN_LOW:     rdata_next = en_low_reg;
                lcf_pkg::ADDR_OPEN_HIGH:  rdata_next = lcf_pkg::lcf_half(open_flag_reg, 1'b1);  // see [R4]
                lcf_pkg::ADDR_OPEN_LOW:   rdata_next = lcf_pkg::lcf_half(open_flag_reg, 1'b0);  // see [R5]
                lcf_pkg::ADDR_SHORT_HIGH: rdata_next = lcf_pkg::lcf_half(short_flag_reg, 1'b1); // see [R8]
                lcf_pkg::ADDR_SHORT_LOW:  rdata_next = lcf_pkg::lcf_half(short_flag_reg, 1'b0); // see [R12]
                default:                  rdata_next = lcf_pkg::UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= lcf_pkg::RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA = rdata_reg;

    // ========================================================================
    // checks
    // warm-up count so depth-three history is not taken from before reset
    logic [1:0] warm_reg, warm_next;

    always_comb begin
        warm_next = warm_reg;
        if (warm_reg != lcf_pkg::SYNC_LAT) begin
            warm_next = warm_reg + 2'h1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            warm_reg <= 2'h0;
        end else begin
            warm_reg <= warm_next;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_en_low_write: assert property ( // see [R1] see [R3]
        REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW
        |=> CHAN_ON[7:0] == $past(REG_REQ.wdata))
        else $error("low enable write not stored");

    // a read in the cycle of a write returns the old value, as the past value does
    a_en_low_read: assert property ( // see [R3]
        REG_REQ.rd && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW
        |=> REG_RDATA == $past(CHAN_ON[7:0]))
        else $error("low enable register not read back");

    a_en_high_write: assert property ( // see [R11]
        REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_HIGH
        |=> CHAN_ON[15:8] == $past(REG_REQ.wdata))
        else $error("high enable write not stored");

    a_chan_gate_off: assert property ( // see [R2]
        REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW && REG_REQ.wdata == 8'h00
        ##1 !(REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW)
        |=> CHAN_ON[7:0] == 8'h00)
        else $error("disabled channel left on");

    a_open_sets: assert property ( // see [R6]
        warm_reg == lcf_pkg::SYNC_LAT
        |-> (open_flag_reg & $past(OPEN_DET, 3)) == $past(OPEN_DET, 3))
        else $error("open fault not flagged three cycles after detection");

    a_open_no_false: assert property ( // see [R7]
        warm_reg == lcf_pkg::SYNC_LAT
        |-> (open_flag_reg & ~$past(open_flag_reg) & ~$past(OPEN_DET, 3)) == 16'h0000)
        else $error("open flag set with no fault");

    a_short_sets: assert property ( // see [R9]
        warm_reg == lcf_pkg::SYNC_LAT
        |-> (short_flag_reg & $past(SHORT_DET, 3)) == $past(SHORT_DET, 3))
        else $error("short fault not flagged three cycles after detection");

    a_short_no_false: assert property ( // see [R10]
        warm_reg == lcf_pkg::SYNC_LAT
        |-> (short_flag_reg & ~$past(short_flag_reg) & ~$past(SHORT_DET, 3)) == 16'h0000)
        else $error("short flag set with no fault");

    a_flags_sticky: assert property ( // see [R13]
        ((($past(open_flag_reg) & ~open_flag_reg) | ($past(short_flag_reg) & ~short_flag_reg))
         == 16'h0000))
        else $error("fault flag cleared without reset");

    a_read_open: assert property ( // see [R4] see [R5]
        REG_REQ.rd && (REG_REQ.addr == lcf_pkg::ADDR_OPEN_HIGH || REG_REQ.addr == lcf_pkg::ADDR_OPEN_LOW)
        |=> REG_RDATA == ($past(REG_REQ.addr) == lcf_pkg::ADDR_OPEN_HIGH
                          ? $past(open_flag_reg[15:8]) : $past(open_flag_reg[7:0])))
        else $error("open fault read returned wrong byte");

    a_read_short: assert property ( // see [R8] see [R12]
        REG_REQ.rd && (REG_REQ.addr == lcf_pkg::ADDR_SHORT_HIGH || REG_REQ.addr == lcf_pkg::ADDR_SHORT_LOW)
        |=> REG_RDATA == ($past(REG_REQ.addr) == lcf_pkg::ADDR_SHORT_HIGH
                          ? $past(short_flag_reg[15:8]) : $past(short_flag_reg[7:0])))
        else $error("short fault read returned wrong byte");

    a_read_unmapped: assert property (
        REG_REQ.rd && (REG_REQ.addr < lcf_pkg::ADDR_EN_HIGH || REG_REQ.addr > lcf_pkg::ADDR_SHORT_LOW)
        |=> REG_RDATA == lcf_pkg::UNMAPPED)
        else $error("unmapped read not zero");

    c_disable_chan: cover property (
        REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_EN_LOW ##1 CHAN_ON[7:0] != 8'hff);
    c_open_seen: cover property (
        open_flag_reg != 16'h0000 ##1 REG_REQ.rd && REG_REQ.addr == lcf_pkg::ADDR_OPEN_LOW);
    c_short_seen: cover property (
        short_flag_reg != 16'h0000 ##1 REG_REQ.rd && REG_REQ.addr == lcf_pkg::ADDR_SHORT_HIGH);
    c_fault_write: cover property (
        REG_REQ.wr && REG_REQ.addr == lcf_pkg::ADDR_OPEN_HIGH && open_flag_reg != 16'h0000);

endmodule : lcf_regs

`default_nettype wire

// [lcf_pkg.sv]
// constants and carrier types for the channel enable and fault register bank
package lcf_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] ADDR_EN_HIGH    = 8'h04;
    localparam logic [7:0] ADDR_EN_LOW     = 8'h05;
    localparam logic [7:0] ADDR_OPEN_HIGH  = 8'h06;
    localparam logic [7:0] ADDR_OPEN_LOW   = 8'h07;
    localparam logic [7:0] ADDR_SHORT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_SHORT_LOW  = 8'h09;

    // ========================================================================
    // reset values, unmapped read data and synchroniser latency
    localparam logic [7:0]  EN_RST     = 8'hff;
    localparam logic [15:0] FLAG_RST   = 16'h0000;
    localparam logic [7:0]  RDATA_RST  = 8'h00;
    localparam logic [7:0]  UNMAPPED   = 8'h00;
    localparam logic [1:0]  SYNC_LAT   = 2'h3;

    // ========================================================================
    // carrier types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lcf_req_t;

    typedef struct packed {
        logic chan_eight_on;
        logic chan_seven_on;
        logic chan_six_on;
        logic chan_five_on;
        logic chan_four_on;
        logic chan_three_on;
        logic chan_two_on;
        logic chan_one_on;
    } lcf_en_low_t;

    // ========================================================================
    // upper or lower byte of a sixteen-channel vector
    function automatic logic [7:0] lcf_half(input logic [15:0] vec, input logic upper);
        lcf_half = upper ? vec[15:8] : vec[7:0];
    endfunction : lcf_half

endpackage : lcf_pkg

// [lcf_regs_dummy_never.sv]
// no logic here: the whole register bank lives in lcf_regs

// [lcf_host.sv]
// host-side requester that drives one-cycle register requests into the bank
`timescale 1ns/1ns
`default_nettype none

module lcf_host (
    input  wire logic             CLK,
    output var lcf_pkg::lcf_req_t REG_REQ,
    input  wire logic [7:0]       REG_RDATA
);
    // ========================================================================
    // request tasks, changed only at falling edges
    initial REG_REQ = '0;

    task automatic host_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge CLK);
        REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge CLK);
        REG_REQ.wr = 1'b0;
    endtask : host_write

    // read data is registered at the taking edge and sampled at the next falling edge
    task automatic host_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge CLK);
        REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge CLK);
        REG_REQ.rd = 1'b0;
        data = REG_RDATA;
    endtask : host_read
endmodule : lcf_host

`default_nettype wire

// [testbench.sv]
// self-checking bench for the channel enable and fault register bank
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } lcf_row_t;

    logic              CLK;
    logic              RST;
    logic [15:0]       OPEN_DET;
    logic [15:0]       SHORT_DET;
    logic [15:0]       CHAN_ON;
    logic [7:0]        REG_RDATA;
    lcf_pkg::lcf_req_t REG_REQ;
    logic [15:0]       en_exp;
    logic [7:0]        d;
    int                miscompares;
    int                tests_run;
    lcf_row_t          rows [9];
    logic [7:0]        flag_exp [4];

    lcf_regs dut_u (.CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
                    .OPEN_DET(OPEN_DET), .SHORT_DET(SHORT_DET), .CHAN_ON(CHAN_ON));
    lcf_host host_u (.CLK(CLK), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // ========================================================================
    // comparison and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ========================================================================
    // main sequence
    initial begin
        miscompares = 0;
        tests_run = 0;
        RST = 1'b1;
        OPEN_DET = 16'h0000;
        SHORT_DET = 16'h0000;
        // writes to flag registers and an unmapped place must leave reads at zero
        rows = '{'{8'h05, 8'h00, 8'h00}, '{8'h05, 8'ha5, 8'ha5}, '{8'h04, 8'h3c, 8'h3c},
                 '{8'h06, 8'hff, 8'h00}, '{8'h07, 8'hff, 8'h00}, '{8'h08, 8'hff, 8'h00},
                 '{8'h09, 8'hff, 8'h00}, '{8'h0b, 8'hff, 8'h00}, '{8'h05, 8'h5a, 8'h5a}};
        flag_exp = '{8'h80, 8'h01, 8'h01, 8'h80};
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        check(CHAN_ON, 16'hffff);
        check({8'h00, REG_RDATA}, 16'h0000);
        host_u.host_read(lcf_pkg::ADDR_EN_LOW, d);
        check({8'h00, d}, 16'h00ff);
        en_exp = 16'hffff;
        foreach (rows[i]) begin
            host_u.host_write(rows[i].addr, rows[i].wdata);
            if (rows[i].addr == lcf_pkg::ADDR_EN_LOW) en_exp[7:0] = rows[i].wdata;
            if (rows[i].addr == lcf_pkg::ADDR_EN_HIGH) en_exp[15:8] = rows[i].wdata;
            check(CHAN_ON, en_exp);
            host_u.host_read(rows[i].addr, d);
            check({8'h00, d}, {8'h00, rows[i].rexp});
        end
        // short detector pulses; flags must stay set after the detectors drop
        @(negedge CLK);
        OPEN_DET = 16'h8001;
        SHORT_DET = 16'h0180;
        repeat (2) @(negedge CLK);
        OPEN_DET = 16'h0000;
        SHORT_DET = 16'h0000;
        repeat (4) @(negedge CLK);
        host_u.host_write(lcf_pkg::ADDR_OPEN_LOW, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host_u.host_read(lcf_pkg::ADDR_OPEN_HIGH + 8'(i), d);
            check({8'h00, d}, {8'h00, flag_exp[i]});
        end
        // second reset in mid-run clears flags and re-enables every channel
        @(negedge CLK);
        RST = 1'b1;
        @(negedge CLK);
        check(CHAN_ON, 16'hffff);
        check({8'h00, REG_RDATA}, 16'h0000);
        RST = 1'b0;
        for (int i = 0; i < 4; i++) begin
            host_u.host_read(lcf_pkg::ADDR_OPEN_HIGH + 8'(i), d);
            check({8'h00, d}, 16'h0000);
        end
        tally_and_finish();
    end

    // ========================================================================
    // watchdog, far beyond the seventy or so cycles the run needs
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
